// ---- core/tunable_filter_spi_pkg.sv ----
// package: register map, frame layout and carrier types of the filter config port
package tunable_filter_spi_pkg;
   localparam int        ADDR_W         = 15;
   localparam int        DATA_W         = 8;
   localparam int        HEADER_BITS    = 16;
   localparam int        COEF_COUNT     = 16;
   localparam int        LUT_BYTES      = 96;
   localparam int        ENTRY_BYTES    = 3;
   localparam int        LUT_ENTRIES    = 32;
   localparam logic [4:0] HDR_CNT_W_MAX = 5'h10;
   localparam logic [2:0] LAST_BIT      = 3'h7;

   localparam logic [14:0] INTERFACE_CONFIG_ADDR = 15'h0000;
   localparam logic [14:0] CENTER_FREQ_ADDR      = 15'h0020;
   localparam logic [14:0] BANDWIDTH_ADDR        = 15'h0021;
   localparam logic [14:0] MATCH_ADDR            = 15'h0022;
   localparam logic [14:0] COEF_BASE_ADDR        = 15'h0030;
   localparam logic [14:0] INTERP_CONTROL_ADDR   = 15'h0050;
   localparam logic [14:0] READBACK_FC_ADDR      = 15'h0060;
   localparam logic [14:0] READBACK_BW_ADDR      = 15'h0061;
   localparam logic [14:0] READBACK_MATCH_ADDR   = 15'h0062;
   localparam logic [14:0] LUT_BASE_ADDR         = 15'h0100;

   localparam logic [7:0] STREAM_ASCEND_KEY     = 8'h3c;
   localparam logic [7:0] INTERFACE_CONFIG_RST  = 8'h00;
   localparam logic [7:0] LOAD_VALUE_RST        = 8'h00;
   localparam logic [7:0] INTERP_CONTROL_RST    = 8'h00;
   localparam int         CURVE_FIT_BIT         = 0;
   localparam logic [7:0] COEF_DEFAULT          = 8'h80;

   typedef struct packed {
      logic [7:0] centerCode;
      logic [7:0] bandwidthCode;
      logic [7:0] matchCode;
   } capCodes_type;

   typedef struct packed {
      logic chipSelect_n;
      logic sclk;
      logic sdi;
      logic fastLatchSelect;
   } spiPins_type;

   typedef logic [COEF_COUNT-1:0][7:0] coefBank_type;
endpackage : tunable_filter_spi_pkg

// ---- core/tunable_filter_spi_config.sv ----
// serial configuration port of the tunable band-pass filter
// Summary of operation
// - frame: direction bit, 15-bit address, 8 data
// - first bit 0 writes, 1 reads
// - write bits sampled on rising serial clock
// - read data out msb first on falling
// - sdo driven after last header rising edge
// - sdo released whenever chip select is high
// - fast latch steps through lookup table entries
// - write group sits at 0x020 to 0x022
// - streaming on when config register holds 0x3c
// - write group stream: 0x020, three bytes
// - table stream: 0x100, 96 bytes
// - curve-fit enable applies the interpCodes input instead of the loads
// - center value 0..255 spans low to high
// - three 8-bit load values set capacitors
// - coefficients reset to nominal defaults
// - fast latch: latch on cs rise, ignore spi
// - 0x060..0x062 read back applied codes
// - chip reset returns registers to defaults
`timescale 1ns/1ps
`default_nettype none
module tunable_filter_spi_config #(
   parameter logic [7:0] COEF_RESET = tunable_filter_spi_pkg::COEF_DEFAULT
) (
   input  wire logic                                 mclk,
   input  wire logic                                 arst_n,
   input  wire tunable_filter_spi_pkg::spiPins_type  pins,
   input  wire tunable_filter_spi_pkg::capCodes_type interpCodes,
   output logic                                      sdo,
   output logic                                      sdoEn,
   output logic                                      curveFitEnable,
   output logic                                      fastLatchActive,
   output tunable_filter_spi_pkg::coefBank_type      coefficients,
   output tunable_filter_spi_pkg::capCodes_type      appliedCodes
);
   localparam int LUT_IDX_W = $clog2(tunable_filter_spi_pkg::LUT_ENTRIES);

   // pins are asynchronous to mclk; two flops before any use
   tunable_filter_spi_pkg::spiPins_type pinMeta;
   tunable_filter_spi_pkg::spiPins_type pinSync;
   tunable_filter_spi_pkg::spiPins_type pinPrev;

   // register file
   logic [7:0]                           interfaceConfig;
   logic [7:0]                           centerFreqLoadWrite;
   logic [7:0]                           bandwidthLoad;
   logic [7:0]                           matchLoad;
   logic [7:0]                           interpControl;
   logic [7:0]                           lut [tunable_filter_spi_pkg::LUT_BYTES];
   tunable_filter_spi_pkg::coefBank_type coefBank;
   logic [7:0]                           next_interfaceConfig;
   logic [7:0]                           next_centerFreqLoadWrite;
   logic [7:0]                           next_bandwidthLoad;
   logic [7:0]                           next_matchLoad;
   logic [7:0]                           next_interpControl;
   logic [7:0]                           next_lut [tunable_filter_spi_pkg::LUT_BYTES];
   tunable_filter_spi_pkg::coefBank_type next_coefBank;

   // frame engine
   logic [4:0]                           hdrCnt;
   logic [2:0]                           bitCnt;
   logic                                 readOp;
   logic                                 firstDone;
   logic [14:0]                          addr;
   logic [7:0]                           dataShift;
   logic [7:0]                           sdoShift;
   logic [4:0]                           next_hdrCnt;
   logic [2:0]                           next_bitCnt;
   logic                                 next_readOp;
   logic                                 next_firstDone;
   logic [14:0]                          next_addr;
   logic [7:0]                           next_dataShift;
   logic [7:0]                           next_sdoShift;
   logic                                 next_sdo;
   logic                                 next_sdoEn;

   // applied capacitor state and fast latch pointer
   logic [LUT_IDX_W-1:0]                 lutIdx;
   logic [LUT_IDX_W-1:0]                 next_lutIdx;
   tunable_filter_spi_pkg::capCodes_type next_appliedCodes;
   logic                                 sclkRise;
   logic                                 sclkFall;
   logic                                 csRise;
   logic                                 streamOn;
   logic                                 wrEn;
   logic [7:0]                           rxByte;

   function automatic logic inRange(input logic [14:0] a, input logic [14:0] base,
                                    input int count);
      inRange = (a >= base) && ({2'b00, a} < {2'b00, base} + 17'(count));
   endfunction : inRange

   function automatic logic [7:0] readByte(input logic [14:0] a);
      logic [14:0] coefOff;
      logic [14:0] lutOff;
      coefOff = a - tunable_filter_spi_pkg::COEF_BASE_ADDR;
      lutOff  = a - tunable_filter_spi_pkg::LUT_BASE_ADDR;
      case (a)
         tunable_filter_spi_pkg::INTERFACE_CONFIG_ADDR: readByte = interfaceConfig;
         tunable_filter_spi_pkg::CENTER_FREQ_ADDR: readByte = centerFreqLoadWrite;
         tunable_filter_spi_pkg::BANDWIDTH_ADDR: readByte = bandwidthLoad;
         tunable_filter_spi_pkg::MATCH_ADDR: readByte = matchLoad;
         tunable_filter_spi_pkg::INTERP_CONTROL_ADDR: readByte = interpControl;
         tunable_filter_spi_pkg::READBACK_FC_ADDR: readByte = appliedCodes.centerCode;
         tunable_filter_spi_pkg::READBACK_BW_ADDR: readByte = appliedCodes.bandwidthCode;
         tunable_filter_spi_pkg::READBACK_MATCH_ADDR: readByte = appliedCodes.matchCode;
         default:
         begin
            readByte = 8'h00;
            if (inRange(a, tunable_filter_spi_pkg::COEF_BASE_ADDR,
                        tunable_filter_spi_pkg::COEF_COUNT))
               readByte = coefBank[coefOff[3:0]];
            else if (inRange(a, tunable_filter_spi_pkg::LUT_BASE_ADDR,
                             tunable_filter_spi_pkg::LUT_BYTES))
               readByte = lut[lutOff[6:0]];
         end
      endcase
   endfunction : readByte

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pinMeta <= '{chipSelect_n: 1'b1, default: 1'b0}; // idle levels: no false edge
         pinSync <= '{chipSelect_n: 1'b1, default: 1'b0};
         pinPrev <= '{chipSelect_n: 1'b1, default: 1'b0};
      end
      else
      begin
         pinMeta <= pins;
         pinSync <= pinMeta;
         pinPrev <= pinSync;
      end
   end

   assign sclkRise        = pinSync.sclk && !pinPrev.sclk;
   assign sclkFall        = !pinSync.sclk && pinPrev.sclk;
   assign csRise          = pinSync.chipSelect_n && !pinPrev.chipSelect_n;
   assign streamOn        = (interfaceConfig == tunable_filter_spi_pkg::STREAM_ASCEND_KEY);
   assign fastLatchActive = pinSync.fastLatchSelect;
   assign rxByte          = {dataShift[6:0], pinSync.sdi};

   // frame engine: header on rising edges, data in or out per byte
   always_comb
   begin
      next_hdrCnt    = hdrCnt;
      next_bitCnt    = bitCnt;
      next_readOp    = readOp;
      next_firstDone = firstDone;
      next_addr      = addr;
      next_dataShift = dataShift;
      next_sdoShift  = sdoShift;
      next_sdo       = sdo;
      next_sdoEn     = sdoEn;
      wrEn           = 1'b0;
      if (pinSync.chipSelect_n || pinSync.fastLatchSelect)
      begin
         // idle, or fast latch where the serial pins are ignored
         next_hdrCnt    = '0;
         next_bitCnt    = '0;
         next_firstDone = 1'b0;
         next_sdoEn     = 1'b0;
         next_sdo       = 1'b0;
      end
      else if (sclkRise)
      begin
         if (hdrCnt == '0)
         begin
            next_readOp = pinSync.sdi;
            next_hdrCnt = hdrCnt + 5'h01;
         end
         else if (hdrCnt != tunable_filter_spi_pkg::HDR_CNT_W_MAX)
         begin
            next_addr   = {addr[13:0], pinSync.sdi};
            next_hdrCnt = hdrCnt + 5'h01;
            if (hdrCnt == tunable_filter_spi_pkg::HDR_CNT_W_MAX - 5'h01 && readOp)
            begin
               next_sdoShift = readByte({addr[13:0], pinSync.sdi});
               next_sdoEn    = 1'b1;
            end
         end
         else
         begin
            next_dataShift = rxByte;
            next_bitCnt    = bitCnt + 3'h1;
            if (bitCnt == tunable_filter_spi_pkg::LAST_BIT)
            begin
               // only whole bytes commit; a cut-off byte is dropped
               next_firstDone = 1'b1;
               wrEn = !readOp && (!firstDone || streamOn);
               if (streamOn)
                  next_addr = addr + 15'h0001;
               if (readOp)
                  next_sdoShift = streamOn ? readByte(addr + 15'h0001) : 8'h00;
            end
         end
      end
      else if (sclkFall && sdoEn)
      begin
         next_sdo      = sdoShift[7];
         next_sdoShift = {sdoShift[6:0], 1'b0};
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hdrCnt    <= '0;
         bitCnt    <= '0;
         readOp    <= 1'b0;
         firstDone <= 1'b0;
         addr      <= '0;
         dataShift <= '0;
         sdoShift  <= '0;
         sdo       <= 1'b0;
         sdoEn     <= 1'b0;
      end
      else
      begin
         hdrCnt    <= next_hdrCnt;
         bitCnt    <= next_bitCnt;
         readOp    <= next_readOp;
         firstDone <= next_firstDone;
         addr      <= next_addr;
         dataShift <= next_dataShift;
         sdoShift  <= next_sdoShift;
         sdo       <= next_sdo;
         sdoEn     <= next_sdoEn;
      end
   end

   // register writes from completed bytes
   always_comb
   begin
      next_interfaceConfig     = interfaceConfig;
      next_centerFreqLoadWrite = centerFreqLoadWrite;
      next_bandwidthLoad       = bandwidthLoad;
      next_matchLoad           = matchLoad;
      next_interpControl       = interpControl;
      next_coefBank            = coefBank;
      next_lut                 = lut;
      if (wrEn)
      begin
         if (addr == tunable_filter_spi_pkg::INTERFACE_CONFIG_ADDR)
            next_interfaceConfig = rxByte;
         if (addr == tunable_filter_spi_pkg::CENTER_FREQ_ADDR)
            next_centerFreqLoadWrite = rxByte;
         if (addr == tunable_filter_spi_pkg::BANDWIDTH_ADDR)
            next_bandwidthLoad = rxByte;
         if (addr == tunable_filter_spi_pkg::MATCH_ADDR)
            next_matchLoad = rxByte;
         if (addr == tunable_filter_spi_pkg::INTERP_CONTROL_ADDR)
            next_interpControl = rxByte;
         for (int i = 0; i < tunable_filter_spi_pkg::COEF_COUNT; i++)
            if (addr == tunable_filter_spi_pkg::COEF_BASE_ADDR + 15'(i))
               next_coefBank[i] = rxByte;
         for (int i = 0; i < tunable_filter_spi_pkg::LUT_BYTES; i++)
            if (addr == tunable_filter_spi_pkg::LUT_BASE_ADDR + 15'(i))
               next_lut[i] = rxByte;
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         interfaceConfig     <= tunable_filter_spi_pkg::INTERFACE_CONFIG_RST;
         centerFreqLoadWrite <= tunable_filter_spi_pkg::LOAD_VALUE_RST;
         bandwidthLoad       <= tunable_filter_spi_pkg::LOAD_VALUE_RST;
         matchLoad           <= tunable_filter_spi_pkg::LOAD_VALUE_RST;
         interpControl       <= tunable_filter_spi_pkg::INTERP_CONTROL_RST;
         coefBank            <= {tunable_filter_spi_pkg::COEF_COUNT{COEF_RESET}};
         lut                 <= '{default: 8'h00};
      end
      else
      begin
         interfaceConfig     <= next_interfaceConfig;
         centerFreqLoadWrite <= next_centerFreqLoadWrite;
         bandwidthLoad       <= next_bandwidthLoad;
         matchLoad           <= next_matchLoad;
         interpControl       <= next_interpControl;
         coefBank            <= next_coefBank;
         lut                 <= next_lut;
      end
   end

   assign curveFitEnable = interpControl[tunable_filter_spi_pkg::CURVE_FIT_BIT];
   assign coefficients   = coefBank;

   // applied codes: table entry in fast latch, else curve fit or direct loads
   always_comb
   begin
      next_lutIdx       = lutIdx;
      next_appliedCodes = appliedCodes;
      if (pinSync.fastLatchSelect)
      begin
         if (csRise)
         begin
            next_appliedCodes = {lut[7'(lutIdx) * 7'd3],
                                 lut[7'(lutIdx) * 7'd3 + 7'd1],
                                 lut[7'(lutIdx) * 7'd3 + 7'd2]};
            next_lutIdx = (32'(lutIdx) == tunable_filter_spi_pkg::LUT_ENTRIES - 1)
                          ? '0 : lutIdx + 1'b1;
         end
      end
      else
      begin
         // pointer restarts so each fast latch run begins at entry 0
         next_lutIdx = '0;
         if (curveFitEnable)
            next_appliedCodes = interpCodes;
         else
            next_appliedCodes = {centerFreqLoadWrite, bandwidthLoad, matchLoad};
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lutIdx       <= '0;
         appliedCodes <= '0;
      end
      else
      begin
         lutIdx       <= next_lutIdx;
         appliedCodes <= next_appliedCodes;
      end
   end
endmodule : tunable_filter_spi_config
`default_nettype wire

// ---- testbench/tunable_filter_spi_config_asserts.sv ----
// checker: port-level timing rules of the filter config port
`timescale 1ns/1ps
`default_nettype none
module tunable_filter_spi_config_asserts #(
   parameter logic [7:0] COEF_RESET = 8'h80
) (
   input wire logic                                 mclk,
   input wire logic                                 arst_n,
   input wire tunable_filter_spi_pkg::spiPins_type  pins,
   input wire tunable_filter_spi_pkg::capCodes_type interpCodes,
   input wire logic                                 sdo,
   input wire logic                                 sdoEn,
   input wire logic                                 curveFitEnable,
   input wire logic                                 fastLatchActive,
   input wire tunable_filter_spi_pkg::coefBank_type coefficients,
   input wire tunable_filter_spi_pkg::capCodes_type appliedCodes
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   a_sdo_released: assert property (pins.chipSelect_n [*6] |-> !sdoEn)
      else $error("sdo driven while chip select high");
   a_drive_in_frame: assert property ($rose(sdoEn) |-> !pins.chipSelect_n && !pins.fastLatchSelect)
      else $error("sdo enabled outside a normal frame");
   // host half period >= 6 cycles, so a falling-edge shift lands in the low phase
   a_sdo_on_fall: assert property (sdoEn && $past(sdoEn) && $changed(sdo) |-> !$past(pins.sclk, 2))
      else $error("sdo changed away from falling serial clock");
   a_fast_follow: assert property ($rose(pins.fastLatchSelect) |-> ##[1:4] fastLatchActive)
      else $error("fast latch select not taken");
   a_fast_quiet: assert property (fastLatchActive [*4] |-> !sdoEn)
      else $error("sdo driven in fast latch mode");
   a_fast_step: assert property (fastLatchActive && $rose(pins.chipSelect_n) |-> ##[2:6] $changed(appliedCodes))
      else $error("no table step on chip select rise");
   a_fast_cause: assert property (fastLatchActive && $changed(appliedCodes) |-> $past(pins.chipSelect_n, 2))
      else $error("table step without chip select rise");
   a_curve_follow: assert property (curveFitEnable && $past(curveFitEnable) && !fastLatchActive
      && !$past(fastLatchActive) |-> appliedCodes == $past(interpCodes))
      else $error("applied codes not following interpolation");
   a_direct_cause: assert property ($changed(appliedCodes) && !curveFitEnable && !$past(curveFitEnable, 3)
      && !fastLatchActive && !$past(fastLatchActive, 3) |-> !$past(pins.chipSelect_n, 5))
      else $error("applied codes changed outside a write");
   a_coef_default: assert property ($rose(arst_n) |-> coefficients == {16{COEF_RESET}})
      else $error("coefficients not at default after reset");
   c_read: cover property (sdoEn [*8]);
   c_curve: cover property (curveFitEnable && $changed(appliedCodes));
   c_fast: cover property (fastLatchActive && $changed(appliedCodes));
endmodule : tunable_filter_spi_config_asserts
bind tunable_filter_spi_config tunable_filter_spi_config_asserts #(.COEF_RESET(COEF_RESET)) u_chk (
   .mclk(mclk), .arst_n(arst_n), .pins(pins), .interpCodes(interpCodes), .sdo(sdo),
   .sdoEn(sdoEn), .curveFitEnable(curveFitEnable), .fastLatchActive(fastLatchActive),
   .coefficients(coefficients), .appliedCodes(appliedCodes));
`default_nettype wire

// ---- testbench/spi_host_model.sv ----
// host serial controller model driving the config port pins
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   input  wire logic                                mclk,
   input  wire logic                                sdo,
   input  wire logic                                sdoEn,
   output var tunable_filter_spi_pkg::spiPins_type  pins
);
   int         half = 6;
   logic [7:0] txd [0:99];
   logic [7:0] rxd [0:99];
   initial pins = 4'b1000;
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask : tick
   // direction bit, 15 address bits, data msb first; cs low whole frame
   task automatic xfer(input logic rdn, input logic [14:0] a, input int nbits);
      logic [15:0] hdr;
      hdr = {rdn, a};
      pins.chipSelect_n = 1'b0;
      for (int i = 0; i < nbits; i++)
      begin
         pins.sdi = (i < 16) ? hdr[15-i] : txd[(i-16)/8][7-(i-16)%8];
         tick(half);
         pins.sclk = 1'b1;
         // released sdo is pulled low
         if (i >= 16)
            rxd[(i-16)/8][7-(i-16)%8] = sdoEn ? sdo : 1'b0;
         tick(half);
         pins.sclk = 1'b0;
      end
      tick(half);
      pins.chipSelect_n = 1'b1;
      pins.sdi = ~pins.sdi;
      tick(half);
   endtask : xfer
   // select low for ordinary access, raised only after table load
   task automatic fastMode(input logic on);
      pins.fastLatchSelect = on;
      tick(6);
   endtask : fastMode
   task automatic latch;
      pins.chipSelect_n = 1'b0;
      tick(half);
      pins.chipSelect_n = 1'b1;
      tick(half);
   endtask : latch
endmodule : spi_host_model
`default_nettype wire

// ---- testbench/tunable_filter_spi_config_tb.sv ----
// testbench: scenario tasks for the filter config port
`timescale 1ns/1ps
`default_nettype none
module tunable_filter_spi_config_tb;
   localparam logic [7:0] COEF_INIT = 8'h5a;
   logic                                 mclk = 1'b0;
   logic                                 arst_n = 1'b0;
   tunable_filter_spi_pkg::capCodes_type interpCodes = 24'h123456;
   tunable_filter_spi_pkg::spiPins_type  pins;
   tunable_filter_spi_pkg::capCodes_type appliedCodes;
   tunable_filter_spi_pkg::coefBank_type coefficients;
   logic                                 sdo;
   logic                                 sdoEn;
   logic                                 curveFitEnable;
   logic                                 fastLatchActive;
   int                                   nErrors = 0;
   int                                   nTests = 0;
   always #10 mclk = ~mclk;
   tunable_filter_spi_config #(.COEF_RESET(COEF_INIT)) dut (.mclk(mclk), .arst_n(arst_n),
      .pins(pins), .interpCodes(interpCodes), .sdo(sdo), .sdoEn(sdoEn),
      .curveFitEnable(curveFitEnable), .fastLatchActive(fastLatchActive),
      .coefficients(coefficients), .appliedCodes(appliedCodes));
   spi_host_model host (.mclk(mclk), .sdo(sdo), .sdoEn(sdoEn), .pins(pins));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nTests++;
      if (seen !== exp)
      begin
         nErrors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrapUp;
      $display("checks %0d mismatches %0d", nTests, nErrors);
      if (nErrors == 0 && nTests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrapUp
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      host.txd[0] = d;
      host.xfer(1'b0, a, 24);
   endtask : wr
   task automatic rdc(input string what, input logic [14:0] a, input logic [7:0] exp);
      host.xfer(1'b1, a, 24);
      check(what, host.rxd[0], exp);
      check("sdoEn after frame", sdoEn, 1'b0);
   endtask : rdc
   task automatic s_reset;
      check("applied reset", appliedCodes, 24'h0);
      check("coef reset", coefficients[3], COEF_INIT);
      rdc("config reset", 15'h0000, 8'h00);
      rdc("coef reg reset", 15'h0035, COEF_INIT);
   endtask : s_reset
   task automatic s_direct;
      wr(15'h0020, 8'ha5);
      check("center applied", appliedCodes.centerCode, 8'ha5);
      rdc("center read", 15'h0020, 8'ha5);
      rdc("readback", 15'h0060, 8'ha5);
      wr(15'h0060, 8'h11);
      rdc("readback ro", 15'h0060, 8'ha5);
      rdc("unmapped", 15'h7fff, 8'h00);
      host.txd[0] = 8'h44;
      host.txd[1] = 8'h77;
      host.xfer(1'b0, 15'h0021, 32);
      rdc("first byte", 15'h0021, 8'h44);
      rdc("no stream", 15'h0022, 8'h00);
   endtask : s_direct
   task automatic s_stream;
      // slower host clock here to show timing margin
      host.half = 9;
      wr(15'h0000, 8'h3c);
      host.txd[0] = 8'h10;
      host.txd[1] = 8'h20;
      host.txd[2] = 8'h30;
      host.xfer(1'b0, 15'h0020, 40);
      check("group write", appliedCodes, 24'h102030);
      host.xfer(1'b1, 15'h0020, 40);
      check("group read", {host.rxd[0], host.rxd[1], host.rxd[2]}, 24'h102030);
      host.txd[0] = 8'hee;
      host.txd[1] = 8'hdd;
      host.xfer(1'b0, 15'h0020, 28);
      check("cut stream", appliedCodes, 24'hee2030);
      host.xfer(1'b0, 15'h0021, 20);
      check("cut byte", appliedCodes, 24'hee2030);
      host.half = 6;
   endtask : s_stream
   task automatic s_curve;
      wr(15'h0050, 8'h01);
      check("curve enable", curveFitEnable, 1'b1);
      for (int k = 0; k < 2; k++)
      begin
         interpCodes = {{8{k[0]}}, 8'h3c, 8'h5a};
         host.tick(3);
         check("curve codes", appliedCodes, interpCodes);
      end
      rdc("curve readback", 15'h0060, 8'hff);
      wr(15'h0050, 8'h00);
      check("direct again", appliedCodes, 24'hee2030);
   endtask : s_curve
   task automatic s_fast;
      for (int k = 0; k < 96; k++)
         host.txd[k] = 8'(k + 1);
      host.xfer(1'b0, 15'h0100, 784);
      rdc("table last", 15'h015f, 8'h60);
      host.fastMode(1'b1);
      check("fast active", fastLatchActive, 1'b1);
      for (int i = 0; i < 3; i++)
      begin
         host.latch();
         check("table entry", appliedCodes, {8'(3*i+1), 8'(3*i+2), 8'(3*i+3)});
      end
      // serial traffic in fast mode only counts as one more latch
      host.xfer(1'b1, 15'h0020, 24);
      check("spi ignored", appliedCodes, 24'h0a0b0c);
      host.fastMode(1'b0);
      check("fast off", fastLatchActive, 1'b0);
   endtask : s_fast
   initial
   begin
      repeat (6) @(posedge mclk);
      #2 arst_n = 1'b1;
      host.tick(4);
      s_reset();
      s_direct();
      s_stream();
      s_curve();
      s_fast();
      wrapUp();
   end
   initial
   begin
      repeat (100000) @(posedge mclk);
      check("watchdog", 1'b1, 1'b0);
      wrapUp();
   end
endmodule : tunable_filter_spi_config_tb
`default_nettype wire
